/* File: include/wdt_regs.svh */
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// ----------------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------------
`define WDT_IDX_RST_CTL      8'hAB
`define WDT_IDX_MAIN_CTL     8'hD8
`define WDT_IDX_EXT_IRQ_EN   8'hE8

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define WDT_MAIN_RUN_EN_BIT  7
`define WDT_MAIN_CLEAR_BIT   6
`define WDT_MAIN_TFLAG_BIT   5
`define WDT_MAIN_SLEEP_BIT   4
`define WDT_MAIN_RFLAG_BIT   3
`define WDT_MAIN_ISEL_LSB    0
`define WDT_RCTL_FN_EN_BIT   0
`define WDT_EIE_WDT_BIT      4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define WDT_RST_CTL_RESET    8'h00
`define WDT_EIE_RESET        8'h00
`define WDT_ISEL_RESET       3'h0
`define WDT_FN_EN_RESET      1'b0

// ----------------------------------------------------------------------
// Timing counts in oscillator ticks
// ----------------------------------------------------------------------
`define WDT_BASE_TICKS_LOG2  6
`define WDT_GRACE_TICKS      10'h200

`endif

/* File: include/wdt_pkg.sv */
package wdt_pkg;

    typedef enum logic [0:0]
    {
        ST_COUNT = 1'b0,
        ST_GRACE = 1'b1
    } grace_state_t;

    typedef enum logic [1:0]
    {
        SEL_NONE = 2'b00,
        SEL_RCTL = 2'b01,
        SEL_MAIN = 2'b10,
        SEL_EIE  = 2'b11
    } reg_sel_t;

    typedef struct packed
    {
        logic       valid;
        logic       write;
        logic [7:0] index;
    } bus_req_t;

    typedef struct packed
    {
        logic       run_enable;
        logic       timeout_flag;
        logic       run_in_sleep;
        logic       watchdog_reset_flag;
        logic [2:0] interval_select;
    } main_ctrl_t;

endpackage : wdt_pkg

/* File: rtl/wdt_tick_counter.sv */
`timescale 1ns/1ps
`include "wdt_regs.svh"

module wdt_tick_counter
    import wdt_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        tick,
    input  wire logic        run,
    input  wire logic        clear,
    input  wire logic [2:0]  interval,
    input  wire logic        rst_fn_en,
    output logic      [14:0] count,
    output logic             timeout,
    output logic             expire
);

    function automatic logic [8:0] prescale_div(input logic [2:0] code);
        case (code)
            3'h0:    prescale_div = 9'h001;
            3'h1:    prescale_div = 9'h002;
            3'h2:    prescale_div = 9'h008;
            3'h3:    prescale_div = 9'h010;
            3'h4:    prescale_div = 9'h020;
            3'h5:    prescale_div = 9'h040;
            3'h6:    prescale_div = 9'h080;
            default: prescale_div = 9'h100;
        endcase
    endfunction : prescale_div

    logic [14:0]  cnt_q;
    logic [14:0]  cnt_d;
    logic [9:0]   grace_q;
    logic [9:0]   grace_d;
    grace_state_t state_q;
    grace_state_t state_d;
    logic         timeout_q;
    logic         expire_q;

    wire logic [14:0] limit    = {prescale_div(interval),
                                  {`WDT_BASE_TICKS_LOG2{1'b0}}};
    wire logic        step     = tick && run;
    wire logic        at_limit = (cnt_q == (limit - 15'h0001));
    wire logic        to_d     = !clear && step && at_limit;
    wire logic        grace_end = (grace_q == (`WDT_GRACE_TICKS - 10'h001));
    wire logic        exp_d    = !clear && step && rst_fn_en
                                 && (state_q == ST_GRACE) && grace_end;

    // ----------------------------------------------------------------------
    // Count and grace sequence
    // ----------------------------------------------------------------------
    // A clear in the same cycle as a tick wins, so a clear is never lost
    assign cnt_d = clear ? 15'h0000 :
                   !step ? cnt_q :
                   at_limit ? 15'h0000 : cnt_q + 15'h0001;

    always_comb
    begin
        state_d = state_q;
        grace_d = grace_q;
        case (state_q)
            ST_COUNT:
            begin
                if (to_d && rst_fn_en)
                begin
                    state_d = ST_GRACE;
                    grace_d = 10'h000;
                end
            end
            ST_GRACE:
            begin
                if (!rst_fn_en || exp_d)
                begin
                    state_d = ST_COUNT;
                    grace_d = 10'h000;
                end
                else if (step)
                begin
                    grace_d = grace_q + 10'h001;
                end
            end
            default:
            begin
                state_d = ST_COUNT;
                grace_d = 10'h000;
            end
        endcase
        if (clear)
        begin
            state_d = ST_COUNT;
            grace_d = 10'h000;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q     <= 15'h0000;
            grace_q   <= 10'h000;
            state_q   <= ST_COUNT;
            timeout_q <= 1'b0;
            expire_q  <= 1'b0;
        end
        else
        begin
            cnt_q     <= cnt_d;
            grace_q   <= grace_d;
            state_q   <= state_d;
            timeout_q <= to_d;
            expire_q  <= exp_d;
        end
    end

    assign count   = cnt_q;
    assign timeout = timeout_q;
    assign expire  = expire_q;

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    a_clear_zeroes_count: assert property (
        @(posedge clk) disable iff (!rst_b)
        clear |=> (cnt_q == 15'h0000))
        else $error("count not zero after clear");

    a_tick_advances: assert property (
        @(posedge clk) disable iff (!rst_b)
        (step && !clear && !at_limit) |=> (cnt_q == $past(cnt_q) + 15'h0001))
        else $error("count did not advance on tick");

    a_timeout_at_limit: assert property (
        @(posedge clk) disable iff (!rst_b)
        $rose(timeout_q) |-> ($past(cnt_q) == ($past(limit) - 15'h0001)))
        else $error("timeout not at selected limit");

    a_grace_expiry: assert property (
        @(posedge clk) disable iff (!rst_b)
        expire_q |-> ($past(grace_q) == 10'h1FF && $past(state_q) == ST_GRACE))
        else $error("reset not 512 ticks after timeout");

endmodule : wdt_tick_counter

/* File: rtl/wdt_timeout_reset.sv */
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`include "wdt_regs.svh"

// Functional notes
// - Writing one to counter clear zeroes the count; the bit self-clears.
// - Clearing run enable (bit 7) stops the count and zeroes it.
// - With run enable at one, the count advances on oscillator ticks.
// - Interval select bits 2:0 pick divisor 1,2,8,16,32,64,128,256.
// - Time-out comes after divisor times 64 ticks since the last clear.
// - At time-out hardware sets the time-out flag, bit 5.
// - With reset function on, no clear within 512 ticks gives reset.
// - With reset function on, time-out still flags and interrupts first.
// - Reset flag bit 3: set by watchdog reset, cleared by power-on.
// - After every reset, run enable loads the inverted config bit.
// - Run-in-sleep bit 4 zero halts count in sleep; one keeps running.
// - Count clears on entering and on leaving sleep.
// - Time-out wakes the system and raises an interrupt event.
// - Run-in-sleep and interval select clear only at power-on.
// - Reset function enable, bit 0, clears only at power-on.
// - Interrupt reaches the core only with enable bit 4 set.
// - Both control registers accept writes only under timed access.
// - Interrupt-only use: reset function off, flag polled, clear reused.

module wdt_timeout_reset
    import wdt_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic      [31:0] HRDATA,
    output logic             HRESP,
    input  wire logic        OSC_TICK,
    input  wire logic        SLEEP_MODE,
    input  wire logic        TIMED_ACCESS_OPEN,
    input  wire logic        CONFIG_WATCHDOG_BIT,
    input  wire logic        OTHER_RESET,
    output logic             TIMEOUT_IRQ,
    output logic             WAKE_UP,
    output logic             WATCHDOG_RESET
);

    function automatic reg_sel_t reg_decode(input logic [7:0] idx);
        case (idx)
            `WDT_IDX_RST_CTL:    reg_decode = SEL_RCTL;
            `WDT_IDX_MAIN_CTL:   reg_decode = SEL_MAIN;
            `WDT_IDX_EXT_IRQ_EN: reg_decode = SEL_EIE;
            default:             reg_decode = SEL_NONE;
        endcase
    endfunction : reg_decode

    bus_req_t    req_q;
    bus_req_t    req_d;
    logic        hready_q;
    logic [31:0] hrdata_q;
    main_ctrl_t  main_q;
    main_ctrl_t  main_d;
    logic        rst_fn_en_q;
    logic [7:0]  eie_q;
    logic        por_load_q;
    logic        sleep_q;
    logic        irq_q;
    logic        wake_q;
    logic        wdt_rst_q;
    logic [14:0] cnt_w;
    logic        timeout_w;
    logic        expire_w;

    // ----------------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------------
    wire logic addr_take = HSEL && HTRANS[1] && HREADY;

    assign req_d = !HREADY ? req_q :
                   addr_take ? bus_req_t'{valid: 1'b1, write: HWRITE,
                                          index: HADDR[9:2]} :
                   bus_req_t'{valid: 1'b0, write: 1'b0, index: 8'h00};

    wire reg_sel_t wr_sel = reg_decode(req_q.index);
    wire logic     wr_en  = req_q.valid && req_q.write && hready_q;
    // Protected registers silently drop writes outside the access window
    wire logic wr_main = wr_en && wr_sel == SEL_MAIN
                         && TIMED_ACCESS_OPEN;
    wire logic wr_rctl = wr_en && wr_sel == SEL_RCTL
                         && TIMED_ACCESS_OPEN;
    wire logic wr_eie  = wr_en && wr_sel == SEL_EIE;
    wire logic rd_load = req_q.valid && !req_q.write && !hready_q;

    wire logic [7:0] main_rd = {main_q.run_enable, 1'b0,
                                main_q.timeout_flag, main_q.run_in_sleep,
                                main_q.watchdog_reset_flag,
                                main_q.interval_select};

    wire logic [7:0] rd_byte = (wr_sel == SEL_MAIN) ? main_rd :
                               (wr_sel == SEL_RCTL) ? {7'h00, rst_fn_en_q} :
                               (wr_sel == SEL_EIE)  ? eie_q : 8'h00;

    // ----------------------------------------------------------------------
    // Bus slave: writes land with no wait, reads take one wait state
    // ----------------------------------------------------------------------
    // The read wait lets a read that follows a write see the new value
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            req_q    <= '{valid: 1'b0, write: 1'b0, index: 8'h00};
            hready_q <= 1'b1;
            hrdata_q <= 32'h0000_0000;
        end
        else
        begin
            req_q    <= req_d;
            hready_q <= !(addr_take && !HWRITE);
            hrdata_q <= rd_load ? {24'h00_0000, rd_byte} : hrdata_q;
        end
    end

    // ----------------------------------------------------------------------
    // Control state
    // ----------------------------------------------------------------------
    wire logic soft_rst  = OTHER_RESET || wdt_rst_q;
    wire logic clr_write = wr_main && HWDATA[`WDT_MAIN_CLEAR_BIT];
    wire logic sleep_edge = SLEEP_MODE != sleep_q;
    wire logic core_clear = clr_write || !main_q.run_enable
                            || sleep_edge || soft_rst || por_load_q;
    wire logic core_run  = main_q.run_enable
                           && (!SLEEP_MODE || main_q.run_in_sleep);

    always_comb
    begin
        main_d = main_q;
        // Hardware set beats a same-cycle software clear
        main_d.timeout_flag = timeout_w || main_q.timeout_flag;
        if (wr_main)
        begin
            main_d.run_enable = HWDATA[`WDT_MAIN_RUN_EN_BIT];
            main_d.run_in_sleep = HWDATA[`WDT_MAIN_SLEEP_BIT];
            main_d.interval_select = HWDATA[`WDT_MAIN_ISEL_LSB +: 3];
            main_d.timeout_flag = timeout_w || (main_q.timeout_flag
                && HWDATA[`WDT_MAIN_TFLAG_BIT]);
            main_d.watchdog_reset_flag = main_q.watchdog_reset_flag
                && HWDATA[`WDT_MAIN_RFLAG_BIT];
        end
        if (soft_rst || por_load_q)
        begin
            main_d.run_enable = !CONFIG_WATCHDOG_BIT;
            main_d.timeout_flag = 1'b0;
        end
        if (wdt_rst_q)
        begin
            main_d.watchdog_reset_flag = 1'b1;
        end
    end

    // Power-on reset is the only asynchronous reset; other resets keep
    // the sleep, interval and reset-function fields; of them, only a watchdog reset changes the reset flag, which it sets.
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            main_q      <= '{run_enable: 1'b0, timeout_flag: 1'b0,
                             run_in_sleep: 1'b0, watchdog_reset_flag: 1'b0,
                             interval_select: `WDT_ISEL_RESET};
            rst_fn_en_q <= `WDT_FN_EN_RESET;
            eie_q       <= `WDT_EIE_RESET;
            por_load_q  <= 1'b1;
        end
        else
        begin
            main_q      <= main_d;
            rst_fn_en_q <= wr_rctl ? HWDATA[`WDT_RCTL_FN_EN_BIT]
                                   : rst_fn_en_q;
            eie_q       <= soft_rst ? `WDT_EIE_RESET :
                           wr_eie ? HWDATA[7:0] : eie_q;
            por_load_q  <= 1'b0;
        end
    end

    // ----------------------------------------------------------------------
    // Outputs and sleep tracking
    // ----------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            sleep_q   <= 1'b0;
            irq_q     <= 1'b0;
            wake_q    <= 1'b0;
            wdt_rst_q <= 1'b0;
        end
        else
        begin
            sleep_q   <= SLEEP_MODE;
            irq_q     <= main_q.timeout_flag
                         && eie_q[`WDT_EIE_WDT_BIT];
            wake_q    <= timeout_w;
            wdt_rst_q <= expire_w && rst_fn_en_q;
        end
    end

    assign HREADYOUT      = hready_q;
    assign HRDATA         = hrdata_q;
    assign HRESP          = 1'b0;
    assign TIMEOUT_IRQ    = irq_q;
    assign WAKE_UP        = wake_q;
    assign WATCHDOG_RESET = wdt_rst_q;

    // ----------------------------------------------------------------------
    // Tick counter
    // ----------------------------------------------------------------------
    wdt_tick_counter u_counter
    (
        .clk       (CLK),
        .rst_b     (RST_B),
        .tick      (OSC_TICK),
        .run       (core_run),
        .clear     (core_clear),
        .interval  (main_q.interval_select),
        .rst_fn_en (rst_fn_en_q),
        .count     (cnt_w),
        .timeout   (timeout_w),
        .expire    (expire_w)
    );

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    a_stop_clears_count: assert property (
        @(posedge CLK) disable iff (!RST_B)
        !main_q.run_enable |=> (cnt_w == 15'h0000))
        else $error("count not held at zero while stopped");

    a_flag_on_timeout: assert property (
        @(posedge CLK) disable iff (!RST_B)
        (timeout_w && !soft_rst && !por_load_q) |=> main_q.timeout_flag)
        else $error("time-out flag not set");

    a_flag_sticky: assert property (
        @(posedge CLK) disable iff (!RST_B)
        (main_q.timeout_flag && !soft_rst && !wr_main)
            |=> main_q.timeout_flag)
        else $error("time-out flag dropped without software");

    a_reset_sets_flag: assert property (
        @(posedge CLK) disable iff (!RST_B)
        wdt_rst_q |=> (main_q.watchdog_reset_flag
                       && main_q.run_enable == !$past(CONFIG_WATCHDOG_BIT)))
        else $error("watchdog reset did not set flag or reload enable");

    a_sleep_edge_clear: assert property (
        @(posedge CLK) disable iff (!RST_B)
        sleep_edge |=> (cnt_w == 15'h0000))
        else $error("count not cleared on sleep change");

    a_sleep_halts: assert property (
        @(posedge CLK) disable iff (!RST_B)
        (SLEEP_MODE && !main_q.run_in_sleep && !core_clear)
            |=> $stable(cnt_w))
        else $error("count moved in sleep without run-in-sleep");

    a_wake_follows: assert property (
        @(posedge CLK) disable iff (!RST_B)
        timeout_w |=> WAKE_UP ##1 !WAKE_UP)
        else $error("wake pulse missing after time-out");

    a_irq_gated: assert property (
        @(posedge CLK) disable iff (!RST_B)
        TIMEOUT_IRQ |-> $past(eie_q[`WDT_EIE_WDT_BIT]))
        else $error("interrupt raised while disabled");

    a_protect_write: assert property (
        @(posedge CLK) disable iff (!RST_B)
        (wr_en && !TIMED_ACCESS_OPEN) |=> ($stable(rst_fn_en_q)
            && $stable(main_q.interval_select)))
        else $error("protected register changed without timed access");

endmodule : wdt_timeout_reset

/* File: test/tb.sv */
`timescale 1ns/1ps
`include "wdt_regs.svh"

module tb
    import wdt_pkg::*;
;
    logic        CLK, RST_B, HSEL, HWRITE, OSC_TICK, SLEEP_MODE;
    logic        TIMED_ACCESS_OPEN, CONFIG_WATCHDOG_BIT, OTHER_RESET;
    logic [31:0] HADDR, HWDATA, HRDATA;
    logic [1:0]  HTRANS;
    logic [2:0]  HSIZE;
    logic        HREADYOUT, HRESP, TIMEOUT_IRQ, WAKE_UP, WATCHDOG_RESET;
    logic [7:0]  m_main, m_rctl, m_eie, r;
    logic [2:0]  s;
    bit          in_grace;
    int          cnt, g, exp_wake, exp_rst, n_wake, n_rst, fails, tests_run;
    int          cyc;
    int          divs [8] = '{1, 2, 8, 16, 32, 64, 128, 256};

    wdt_timeout_reset DUT (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT),
        .HRDATA(HRDATA), .HRESP(HRESP), .OSC_TICK(OSC_TICK),
        .SLEEP_MODE(SLEEP_MODE), .TIMED_ACCESS_OPEN(TIMED_ACCESS_OPEN),
        .CONFIG_WATCHDOG_BIT(CONFIG_WATCHDOG_BIT),
        .OTHER_RESET(OTHER_RESET), .TIMEOUT_IRQ(TIMEOUT_IRQ),
        .WAKE_UP(WAKE_UP), .WATCHDOG_RESET(WATCHDOG_RESET));

    always #50 CLK = ~CLK;

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] sv,
                       input logic [31:0] ev);
        tests_run++;
        if (sv !== ev)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, ev, sv);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    // Pulse counters see the registered outputs before the edge updates
    always @(posedge CLK)
    begin
        cyc++;
        if (WAKE_UP === 1'b1)
            n_wake++;
        if (WATCHDOG_RESET === 1'b1)
            n_rst++;
        if (cyc == 100000)
        begin
            fails++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // Bus master and model
    // ------------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [31:0] rv);
        HSEL   <= 1'b1;
        HTRANS <= 2'b10;
        HADDR  <= {22'h0, idx, 2'b00};
        HWRITE <= w;
        HSIZE  <= 3'h2;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        HSEL   <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= ($urandom() & 32'hFFFFFF00) | {24'h0, wd};
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        rv = HRDATA;
        HWDATA <= ~HWDATA;
    endtask : bus

    function automatic logic [7:0] mexp(input logic [7:0] idx);
        case (idx)
            `WDT_IDX_MAIN_CTL:   return m_main;
            `WDT_IDX_RST_CTL:    return m_rctl;
            `WDT_IDX_EXT_IRQ_EN: return m_eie;
            default:             return 8'h00;
        endcase
    endfunction : mexp

    task automatic rc(input logic [7:0] idx);
        logic [31:0] d;
        bus(1'b0, idx, 8'h00, d);
        chk($sformatf("reg %h", idx), d, {24'h0, mexp(idx)});
    endtask : rc

    task automatic wr(input logic [7:0] idx, input logic [7:0] v,
                      input logic ta);
        logic [31:0] d;
        TIMED_ACCESS_OPEN <= ta;
        bus(1'b1, idx, v, d);
        chk("resp", HRESP, 32'h0000_0000);
        if (idx == `WDT_IDX_EXT_IRQ_EN)
            m_eie = v;
        else if (ta && idx == `WDT_IDX_RST_CTL)
            m_rctl = {7'h0, v[0]};
        else if (ta && idx == `WDT_IDX_MAIN_CTL)
        begin
            if (v[6] || !v[7])
            begin
                cnt = 0;
                in_grace = 0;
            end
            m_main = {v[7], 1'b0, v[5] & m_main[5], v[4],
                      v[3] & m_main[3], v[2:0]};
        end
    endtask : wr

    task automatic mrst(input bit wd);
        m_main = {~CONFIG_WATCHDOG_BIT, 2'b00, m_main[4],
                  m_main[3] | wd, m_main[2:0]};
        m_eie = 8'h00;
        cnt = 0;
        in_grace = 0;
    endtask : mrst

    task automatic por();
        RST_B <= 1'b0;
        repeat (8) @(posedge CLK);
        RST_B <= 1'b1;
        @(posedge CLK);
        m_main = {~CONFIG_WATCHDOG_BIT, 7'h00};
        m_rctl = 8'h00;
        mrst(0);
    endtask : por

    task automatic slp(input logic v);
        SLEEP_MODE <= v;
        @(posedge CLK);
        cnt = 0;
        in_grace = 0;
    endtask : slp

    task automatic tk(input int n);
        repeat (n)
        begin
            OSC_TICK <= 1'b1;
            @(posedge CLK);
            OSC_TICK <= 1'b0;
            @(posedge CLK);
            if (m_main[7] && (!SLEEP_MODE || m_main[4]))
            begin
                cnt++;
                if (in_grace)
                    g++;
                if (in_grace && g == `WDT_GRACE_TICKS)
                begin
                    exp_rst++;
                    mrst(1);
                end
                if (cnt == divs[m_main[2:0]] << `WDT_BASE_TICKS_LOG2)
                begin
                    exp_wake++;
                    m_main[5] = 1'b1;
                    in_grace = m_rctl[0];
                    g = 0;
                    cnt = 0;
                end
            end
        end
    endtask : tk

    task automatic ev();
        repeat (4) @(posedge CLK);
        chk("wake", n_wake, exp_wake);
        chk("reset", n_rst, exp_rst);
        chk("irq", TIMEOUT_IRQ, m_main[5] & m_eie[4]);
    endtask : ev

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial
    begin
        CLK = 0; RST_B = 0; HSEL = 0; HADDR = 0; HTRANS = 0; HWRITE = 0;
        HSIZE = 0; HWDATA = 0; OSC_TICK = 0; SLEEP_MODE = 0;
        TIMED_ACCESS_OPEN = 0; CONFIG_WATCHDOG_BIT = 1; OTHER_RESET = 0;
        r = 8'($urandom(32'hAA3F));
        por();
        rc(`WDT_IDX_MAIN_CTL);
        rc(`WDT_IDX_RST_CTL);
        rc(`WDT_IDX_EXT_IRQ_EN);
        rc(8'h00);
        tk(100); ev();
        wr(`WDT_IDX_MAIN_CTL, 8'h87, 1'b0); rc(`WDT_IDX_MAIN_CTL);
        wr(`WDT_IDX_RST_CTL, 8'h01, 1'b0); rc(`WDT_IDX_RST_CTL);
        wr(`WDT_IDX_EXT_IRQ_EN, r, 1'b0); rc(`WDT_IDX_EXT_IRQ_EN);
        wr(`WDT_IDX_EXT_IRQ_EN, r | 8'h10, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            s = i[2:0];
            wr(`WDT_IDX_MAIN_CTL, {5'h08, s}, 1'b1);
            wr(`WDT_IDX_MAIN_CTL, {5'h18, s}, 1'b1);
            rc(`WDT_IDX_MAIN_CTL);
            tk((divs[i] << 6) - 1); ev();
            tk(1); ev(); rc(`WDT_IDX_MAIN_CTL);
            wr(`WDT_IDX_MAIN_CTL, {5'h14, s}, 1'b1);
            rc(`WDT_IDX_MAIN_CTL);
            wr(`WDT_IDX_MAIN_CTL, {5'h10, s}, 1'b1); ev();
        end
        wr(`WDT_IDX_MAIN_CTL, 8'hC0, 1'b1); tk(40);
        wr(`WDT_IDX_MAIN_CTL, 8'hC0, 1'b1); tk(40); ev();
        tk(24); ev();
        tk(40); wr(`WDT_IDX_MAIN_CTL, 8'h00, 1'b1);
        wr(`WDT_IDX_MAIN_CTL, 8'h80, 1'b1); tk(40); ev();
        wr(`WDT_IDX_MAIN_CTL, 8'hC0, 1'b1); tk(40);
        slp(1'b1); tk(100); ev();
        slp(1'b0); tk(40); ev();
        wr(`WDT_IDX_MAIN_CTL, 8'hD0, 1'b1); tk(30);
        slp(1'b1); tk(63); ev();
        tk(1); ev();
        slp(1'b0);
        wr(`WDT_IDX_MAIN_CTL, 8'hC4, 1'b1);
        wr(`WDT_IDX_RST_CTL, 8'h01, 1'b1); rc(`WDT_IDX_RST_CTL);
        tk(2048); ev();
        tk(500); wr(`WDT_IDX_MAIN_CTL, 8'hE4, 1'b1);
        tk(1537); ev();
        tk(511); ev();
        tk(511); ev();
        tk(1); ev();
        rc(`WDT_IDX_MAIN_CTL);
        rc(`WDT_IDX_RST_CTL);
        rc(`WDT_IDX_EXT_IRQ_EN);
        CONFIG_WATCHDOG_BIT <= 1'b0;
        OTHER_RESET <= 1'b1;
        @(posedge CLK);
        OTHER_RESET <= 1'b0;
        @(posedge CLK);
        mrst(0);
        rc(`WDT_IDX_MAIN_CTL);
        rc(`WDT_IDX_RST_CTL);
        por();
        rc(`WDT_IDX_MAIN_CTL);
        rc(`WDT_IDX_RST_CTL);
        close_out();
    end
endmodule : tb
